//--- design/threshold_pkg.sv
// constants, field layouts and carrier types for the field threshold comparator
// assumes a single system clock; no imports, every use is package-scoped
package threshold_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CAL = 8'h00;
	localparam logic [7:0] IDX_RAW = 8'h01;
	localparam logic [7:0] IDX_OUT_STATE = 8'h03;
	localparam logic [7:0] IDX_LOW = 8'h20;
	localparam logic [7:0] IDX_HIGH = 8'h21;
	localparam logic [7:0] IDX_MARGIN = 8'h22;
	localparam logic [7:0] IDX_INVERT = 8'h23;
	localparam logic [7:0] IDX_ZERO = 8'h24;
	localparam logic [7:0] IDX_MODE = 8'h30;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h31;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h32;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h33;

	// factory defaults; levels and margin in percent of full range
	localparam logic [7:0] LOW_RST = 8'h64;
	localparam logic [7:0] HIGH_RST = 8'h64;
	localparam logic [7:0] MARGIN_RST = 8'h0A;
	localparam logic [7:0] INVERT_RST = 8'h00;
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;

	// field positions and widths
	localparam int MODE_BIT_WINDOW = 0;
	localparam int IRQ_BIT_TRIP = 0;
	localparam int IRQ_BIT_RELEASE = 1;
	localparam int IRQ_BIT_SAMPLE = 2;
	localparam int IRQ_WIDTH = 3;
	localparam int SAMPLE_WIDTH = 10;

	typedef enum logic [1:0] {
		CMP_BELOW,
		CMP_INSIDE,
		CMP_ABOVE
	} cmp_state_t;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic [7:0] margin;
		logic window;
	} trip_cfg_t;

	typedef struct packed {
		logic valid;
		logic signed [SAMPLE_WIDTH-1:0] cal;
		logic signed [SAMPLE_WIDTH-1:0] raw;
	} sample_t;

	typedef struct packed {
		logic valid;
		logic [7:0] cal;
		logic [7:0] raw;
	} reading_t;

	// magnitude of a signed value, saturated to one byte
	function automatic logic [7:0] sat_mag(input logic signed [SAMPLE_WIDTH:0] v);
		logic [SAMPLE_WIDTH:0] m;
		m = v[SAMPLE_WIDTH] ? 11'(-v) : 11'(v);
		return (m > 11'h0FF) ? 8'hFF : m[7:0];
	endfunction

	// a minus b, floored at zero
	function automatic logic [7:0] sub_sat(input logic [7:0] a, input logic [7:0] b);
		return (a > b) ? 8'(a - b) : 8'h00;
	endfunction

endpackage

//--- design/reading_conditioner.sv
// zero correction of the incoming compensated sample, magnitude of the compensated and raw samples
// assumes samples come from logic on the same clock, one valid pulse per sample
`timescale 1ns/1ps
module reading_conditioner (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// sample in
	input threshold_pkg::sample_t sample,
	input wire logic [7:0] zero_corr,
	// conditioned reading out
	output threshold_pkg::reading_t reading
);

	typedef struct packed {
		threshold_pkg::reading_t rd;
	} cond_state_t;

	cond_state_t s_r;
	cond_state_t s_nxt;

	always_comb begin
		logic signed [threshold_pkg::SAMPLE_WIDTH:0] corr;
		corr = '0;
		s_nxt = s_r;
		s_nxt.rd.valid = sample.valid;
		if (sample.valid) begin
			// correction subtracted from the compensated value only
			corr = 11'(sample.cal) - 11'($signed(zero_corr));
			s_nxt.rd.cal = threshold_pkg::sat_mag(corr); // see RULE_13
			s_nxt.rd.raw = threshold_pkg::sat_mag(11'(sample.raw)); // see RULE_07
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reading = s_r.rd;

endmodule

//--- design/trip_comparator.sv
// simple and window comparator with switch-back margin, stepped once per sample
// assumes configuration and magnitude come from the same clock domain
`timescale 1ns/1ps
module trip_comparator (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// magnitude and settings
	input wire logic valid,
	input wire logic [7:0] mag,
	input threshold_pkg::trip_cfg_t cfg,
	// result
	output wire logic active,
	output wire logic trip,
	output wire logic release_ev
);

	typedef struct packed {
		threshold_pkg::cmp_state_t st;
		logic trip;
		logic rel;
	} cmp_reg_t;

	cmp_reg_t s_r;
	cmp_reg_t s_nxt;

	always_comb begin
		logic [7:0] low_back;
		logic [7:0] high_back;
		threshold_pkg::cmp_state_t nx;
		low_back = threshold_pkg::sub_sat(cfg.low, cfg.margin); // see RULE_04
		high_back = threshold_pkg::sub_sat(cfg.high, cfg.margin); // see RULE_14
		nx = s_r.st;
		s_nxt = s_r;
		s_nxt.trip = 1'b0;
		s_nxt.rel = 1'b0;
		if (valid) begin // see RULE_14
			unique case (s_r.st)
				threshold_pkg::CMP_BELOW: begin
					if (mag > cfg.low) begin // see RULE_01
						nx = (cfg.window && mag > cfg.high) ? threshold_pkg::CMP_ABOVE
							: threshold_pkg::CMP_INSIDE;
					end
				end
				threshold_pkg::CMP_INSIDE: begin
					// high level ignored in simple mode
					if (cfg.window && mag > cfg.high) begin // see RULE_02
						nx = threshold_pkg::CMP_ABOVE;
					end else if (mag <= low_back) begin // see RULE_04
						nx = threshold_pkg::CMP_BELOW;
					end
				end
				threshold_pkg::CMP_ABOVE: begin
					if (!cfg.window || mag <= low_back) begin
						nx = threshold_pkg::CMP_BELOW;
					end else if (mag <= high_back) begin // see RULE_14
						nx = threshold_pkg::CMP_INSIDE;
					end
				end
				default: nx = threshold_pkg::CMP_BELOW;
			endcase
			s_nxt.st = nx;
			s_nxt.trip = (nx == threshold_pkg::CMP_INSIDE) && (s_r.st != threshold_pkg::CMP_INSIDE);
			s_nxt.rel = (nx != threshold_pkg::CMP_INSIDE) && (s_r.st == threshold_pkg::CMP_INSIDE);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_r <= '{st: threshold_pkg::CMP_BELOW, trip: 1'b0, rel: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign active = (s_r.st == threshold_pkg::CMP_INSIDE);
	assign trip = s_r.trip;
	assign release_ev = s_r.rel;

endmodule

//--- design/field_threshold_comparator.sv
// top of the field threshold comparator: avalon-mm parameter file,
// interrupt logic and the registered threshold output
// assumes samples arrive from on-chip logic on clock with a one-cycle valid
`timescale 1ns/1ps

// Contract
// RULE_01 - simple mode trips above low level
// RULE_02 - window releases above high; simple ignores high
// RULE_03 - mode selectable, simple is default
// RULE_04 - switch back at level minus margin
// RULE_05 - levels and margin in percent, host writable
// RULE_06 - default trip level is one hundred percent
// RULE_07 - compensated reading primary, raw separately readable
// RULE_08 - host writes zero correction with reading
// RULE_09 - host flags readings beyond linear range
// RULE_10 - low, high, margin at 0x20..0x22
// RULE_11 - nonzero polarity parameter inverts output
// RULE_12 - calibrated at 0, uncompensated at 1
// RULE_13 - readings are magnitudes, polarity independent
// RULE_14 - step per sample, margin on both levels
module field_threshold_comparator (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// sample input
	input threshold_pkg::sample_t sample,
	// outputs
	output logic threshold_out,
	output logic irq
);

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic [7:0] margin;
		logic [7:0] invert;
		logic [7:0] zero;
		logic [7:0] mode;
		logic [threshold_pkg::IRQ_WIDTH-1:0] status;
		logic [threshold_pkg::IRQ_WIDTH-1:0] enable;
		logic dout;
		logic irq;
		logic wait_n;
		logic wait_req;
		logic [31:0] rdata;
	} top_state_t;

	localparam top_state_t TOP_RST = '{
		low: threshold_pkg::LOW_RST,
		high: threshold_pkg::HIGH_RST,
		margin: threshold_pkg::MARGIN_RST,
		invert: threshold_pkg::INVERT_RST,
		zero: threshold_pkg::ZERO_RST,
		mode: threshold_pkg::MODE_RST,
		status: '0,
		enable: '0,
		dout: 1'b0,
		irq: 1'b0,
		wait_n: 1'b0,
		wait_req: 1'b1,
		rdata: 32'h0000_0000
	};

	top_state_t s_r;
	top_state_t s_nxt;

	threshold_pkg::reading_t reading;
	threshold_pkg::trip_cfg_t cfg;
	logic cmp_active;
	logic cmp_trip;
	logic cmp_release;

	// settings steering the comparator
	always_comb begin
		cfg.low = s_r.low;
		cfg.high = s_r.high;
		cfg.margin = s_r.margin;
		cfg.window = s_r.mode[threshold_pkg::MODE_BIT_WINDOW]; // see RULE_03
	end

	reading_conditioner u_cond (
		.clock(clock),
		.reset(reset),
		.sample(sample),
		.zero_corr(s_r.zero), // see RULE_08
		.reading(reading)
	);

	trip_comparator u_cmp (
		.clock(clock),
		.reset(reset),
		.valid(reading.valid),
		.mag(reading.cal),
		.cfg(cfg),
		.active(cmp_active),
		.trip(cmp_trip),
		.release_ev(cmp_release)
	);

	// byte-wide read value of one parameter index
	function automatic logic [31:0] read_word(
		input logic [7:0] idx,
		input top_state_t st,
		input threshold_pkg::reading_t rd
	);
		logic [7:0] b;
		b = 8'h00;
		unique case (idx)
			threshold_pkg::IDX_CAL: b = rd.cal; // see RULE_12
			threshold_pkg::IDX_RAW: b = rd.raw; // see RULE_07
			threshold_pkg::IDX_OUT_STATE: b = {7'h00, st.dout};
			threshold_pkg::IDX_LOW: b = st.low; // see RULE_10
			threshold_pkg::IDX_HIGH: b = st.high;
			threshold_pkg::IDX_MARGIN: b = st.margin;
			threshold_pkg::IDX_INVERT: b = st.invert;
			threshold_pkg::IDX_ZERO: b = st.zero;
			threshold_pkg::IDX_MODE: b = st.mode;
			threshold_pkg::IDX_IRQ_STATUS: b = {5'h00, st.status};
			threshold_pkg::IDX_IRQ_ENABLE: b = {5'h00, st.enable};
			default: b = 8'h00;
		endcase
		return {24'h00_0000, b};
	endfunction

	always_comb begin
		logic [7:0] idx;
		logic wr_now;
		logic [threshold_pkg::IRQ_WIDTH-1:0] events;
		logic [threshold_pkg::IRQ_WIDTH-1:0] clr;
		idx = address[9:2];
		wr_now = write && s_r.wait_n && byteenable[0];
		events = '0;
		clr = '0;
		s_nxt = s_r;

		// one wait cycle, then the access completes
		if ((read || write) && !s_r.wait_n) begin
			s_nxt.wait_n = 1'b1;
			s_nxt.rdata = read ? read_word(idx, s_r, reading) : 32'h0000_0000;
		end else begin
			s_nxt.wait_n = 1'b0;
		end
		// registered copy so the pin comes straight from a flop
		s_nxt.wait_req = !s_nxt.wait_n;

		// write lands at the edge where waitrequest is low
		if (wr_now) begin
			unique case (idx)
				threshold_pkg::IDX_LOW: s_nxt.low = writedata[7:0]; // see RULE_05
				threshold_pkg::IDX_HIGH: s_nxt.high = writedata[7:0]; // see RULE_05
				threshold_pkg::IDX_MARGIN: s_nxt.margin = writedata[7:0]; // see RULE_05
				threshold_pkg::IDX_INVERT: s_nxt.invert = writedata[7:0];
				threshold_pkg::IDX_ZERO: s_nxt.zero = writedata[7:0];
				threshold_pkg::IDX_MODE: s_nxt.mode = writedata[7:0];
				threshold_pkg::IDX_IRQ_CLEAR: clr = writedata[threshold_pkg::IRQ_WIDTH-1:0];
				threshold_pkg::IDX_IRQ_ENABLE: s_nxt.enable = writedata[threshold_pkg::IRQ_WIDTH-1:0];
				default: s_nxt.mode = s_r.mode;
			endcase
		end

		// sticky events; a set in the clearing cycle survives
		events[threshold_pkg::IRQ_BIT_TRIP] = cmp_trip;
		events[threshold_pkg::IRQ_BIT_RELEASE] = cmp_release;
		events[threshold_pkg::IRQ_BIT_SAMPLE] = reading.valid;
		s_nxt.status = (s_r.status & ~clr) | events;
		s_nxt.irq = |(s_nxt.status & s_nxt.enable);

		s_nxt.dout = cmp_active ^ (s_r.invert != 8'h00); // see RULE_11
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_r <= TOP_RST; // see RULE_06
		end else begin
			s_r <= s_nxt;
		end
	end

	assign readdata = s_r.rdata;
	assign waitrequest = s_r.wait_req;
	assign threshold_out = s_r.dout;
	assign irq = s_r.irq;

endmodule

//--- verification/threshold_checker_assertions.sv
// port assertions for the field threshold comparator
// assumes one clock and the one-wait register bus answer
`timescale 1ns/1ps
module threshold_checker (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// register bus
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// sample and outputs
	input wire threshold_pkg::sample_t sample,
	input wire logic threshold_out,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire logic take = (read || write) && waitrequest;
	wire logic rd_take = read && waitrequest;

	wait_one_a: assert property (take |=> !waitrequest)
		else $error("no answer after one wait");
	wait_pulse_a: assert property (!waitrequest |=> waitrequest)
		else $error("wait low too long");
	idle_wait_a: assert property (!read && !write |=> waitrequest)
		else $error("answer without request");
	data_hold_a: assert property (!take |=> $stable(readdata))
		else $error("read data moved");
	byte_wide_a: assert property (readdata[31:8] == 24'h00_0000)
		else $error("upper read data set");
	unmapped_zero_a: assert property (rd_take && address[9:2] == 8'h10 |=> readdata == 0)
		else $error("unmapped read not zero");
	out_state_a: assert property (rd_take && address[9:2] == 8'h03 |=> readdata[0] == $past(threshold_out))
		else $error("output state read wrong");
	out_cause_a: assert property ($changed(threshold_out) |-> $past(sample.valid, 3) || $past(write) || $past(write, 2))
		else $error("output moved without cause");

	cover property ($rose(threshold_out));
	cover property ($fell(threshold_out));
	cover property ($rose(irq));
endmodule

bind field_threshold_comparator threshold_checker u_threshold_checker (
	.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .sample(sample), .threshold_out(threshold_out), .irq(irq)
);

//--- verification/host_model.sv
// host side: register bus master tasks and host bookkeeping
// assumes the slave shares the clock
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic clock,
	// register bus master
	output logic [9:0] address,
	output logic read,
	output logic write,
	output logic [3:0] byteenable,
	output logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// host flag
	output logic range_flag
);
	logic wait_s;
	logic [31:0] data_s;
	initial begin
		address = 10'h000;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'h1;
		writedata = 32'h0000_0000;
		range_flag = 1'b0;
	end
	// values as the next rising edge will see them
	always @(negedge clock) begin
		wait_s <= waitrequest;
		data_s <= readdata;
	end
	task bus_write(input logic [7:0] idx, input logic [7:0] d);
		address <= {idx, 2'b00};
		writedata <= {24'h00_0000, d};
		write <= 1'b1;
		do @(posedge clock); while (wait_s);
		write <= 1'b0;
		@(posedge clock);
	endtask
	task bus_read(input logic [7:0] idx, output logic [31:0] d);
		address <= {idx, 2'b00};
		read <= 1'b1;
		do @(posedge clock); while (wait_s);
		d = data_s;
		read <= 1'b0;
		if (idx == 8'h00) range_flag = d > 32'h0000_0064;
		@(posedge clock);
	endtask
	// write with the low byte lane disabled; the slave must ignore it
	task bus_write_masked(input logic [7:0] idx, input logic [7:0] d);
		byteenable <= 4'h0;
		bus_write(idx, d);
		byteenable <= 4'h1;
	endtask
	// cancel the background with the present reading
	task zero_out;
		logic [31:0] v;
		bus_read(8'h00, v);
		bus_write(8'h24, v[7:0]);
	endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the field threshold comparator
// assumes the host model drives the register bus
`timescale 1ns/1ps
module testbench;
	logic clock;
	logic reset;
	logic [9:0] address;
	logic read;
	logic write;
	logic [3:0] byteenable;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	threshold_pkg::sample_t sample;
	logic threshold_out;
	logic irq;
	logic range_flag;
	int err_count;
	int comparisons;
	logic [31:0] v;

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	field_threshold_comparator u_field_threshold_comparator (.clock(clock), .reset(reset),
		.address(address), .read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.sample(sample), .threshold_out(threshold_out), .irq(irq));
	host_model u_host_model (.clock(clock), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .range_flag(range_flag));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task rd(input logic [7:0] idx, input logic [7:0] exp);
		u_host_model.bus_read(idx, v);
		check(v, {24'h00_0000, exp});
	endtask
	// one sample, then wait for it to reach the output
	task smp(input logic signed [9:0] cal, input logic signed [9:0] raw, input logic q);
		sample <= '{1'b1, cal, raw};
		@(posedge clock);
		sample.valid <= 1'b0;
		repeat (4) @(posedge clock);
		check({31'h0, threshold_out}, {31'h0, q});
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		complete_run();
	end
	initial begin
		reset = 1'b1;
		sample = '0;
		err_count = 0;
		comparisons = 0;
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rd(8'h20, 8'h64);
		rd(8'h21, 8'h64);
		rd(8'h22, 8'h0A);
		rd(8'h23, 8'h00);
		rd(8'h30, 8'h00);
		rd(8'h10, 8'h00);
		u_host_model.bus_write(8'h01, 8'h55);
		rd(8'h01, 8'h00);
		$display("test defaults done");
		smp(-10'sd120, 10'sd7, 1'b1);
		rd(8'h00, 8'h78);
		rd(8'h01, 8'h07);
		check({31'h0, range_flag}, 32'h0000_0001);
		rd(8'h03, 8'h01);
		smp(10'sd91, 10'sd0, 1'b1);
		smp(10'sd90, 10'sd0, 1'b0);
		u_host_model.bus_write(8'h21, 8'h6E);
		smp(10'sd200, 10'sd0, 1'b1);
		smp(10'sd0, 10'sd0, 1'b0);
		$display("test simple done");
		u_host_model.bus_write(8'h30, 8'h01);
		smp(10'sd105, 10'sd0, 1'b1);
		smp(10'sd111, 10'sd0, 1'b0);
		smp(10'sd101, 10'sd0, 1'b0);
		smp(10'sd100, 10'sd0, 1'b1);
		smp(10'sd90, 10'sd0, 1'b0);
		u_host_model.bus_write(8'h30, 8'h00);
		u_host_model.bus_write(8'h23, 8'h01);
		@(posedge clock);
		check({31'h0, threshold_out}, 32'h0000_0001);
		u_host_model.bus_write(8'h23, 8'h00);
		$display("test window and invert done");
		u_host_model.bus_write(8'h20, 8'h32);
		rd(8'h20, 8'h32);
		u_host_model.bus_write_masked(8'h20, 8'h11);
		rd(8'h20, 8'h32);
		smp(10'sd51, 10'sd0, 1'b1);
		smp(10'sd45, 10'sd0, 1'b1);
		smp(10'sd40, 10'sd0, 1'b0);
		u_host_model.bus_write(8'h32, 8'h07);
		smp(10'sd60, 10'sd0, 1'b1);
		check({31'h0, irq}, 32'h0000_0000);
		rd(8'h31, 8'h05);
		u_host_model.bus_write(8'h33, 8'h01);
		@(posedge clock);
		check({31'h0, irq}, 32'h0000_0001);
		u_host_model.bus_write(8'h32, 8'h01);
		@(posedge clock);
		check({31'h0, irq}, 32'h0000_0000);
		rd(8'h31, 8'h04);
		rd(8'h32, 8'h00);
		smp(10'sd30, 10'sd0, 1'b0);
		u_host_model.zero_out();
		smp(10'sd30, 10'sd0, 1'b0);
		rd(8'h00, 8'h00);
		smp(10'sd300, -10'sd300, 1'b1);
		rd(8'h00, 8'hFF);
		rd(8'h01, 8'hFF);
		$display("test irq and zero done");
		complete_run();
	end
endmodule
